// [pio_function_mux.sv]
// pin function mux with apb registers, event capture and time pulse generator
`timescale 1ns/1ps
`default_nettype none
module pio_function_mux
	import pio_mux_pkg::*;
(
	// clock, reset, enable
	input  wire  logic              clk_sys,
	input  wire  logic              rst,
	input  wire  logic              ce,
	// apb slave
	input  wire  logic              psel,
	input  wire  logic              penable,
	input  wire  logic              pwrite,
	input  wire  logic [ADDR_W-1:0] paddr,
	input  wire  logic [31:0]       pwdata,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	output logic                    irq,
	// multiplexed pins
	input  wire  logic [NPIN-1:0]   pin_in,
	output logic [NPIN-1:0]         pin_out,
	output logic [NPIN-1:0]         pin_oe_n,
	output logic [NPIN-1:0]         pull_up_en,
	// serial port cores
	input  wire  logic              pri_txd,
	input  wire  logic              sec_txd,
	output logic                    pri_rxd,
	output logic                    pri_cts,
	output logic                    sec_rxd,
	output logic [BAUD_W-1:0]       pri_baud_div,
	output logic [BAUD_W-1:0]       sec_baud_div,
	// i2c clock on pin 13, open drain
	input  wire  logic              i2c_scl_low,
	output logic                    i2c_scl_in,
	// timing engine
	input  wire  logic [TIME_W-1:0] gps_time,
	input  wire  logic              grid_tick,
	input  wire  logic              speed_pulse,
	output logic                    external_event_line0,
	output logic                    external_event_line1,
	// antenna supervision
	output logic                    antenna_detect_in,
	output logic                    antenna_short_in
);
	mux_cfg_t          cfg;
	logic [NPIN-1:0]   gpio_out;
	logic [NPIN-1:0]   gpio_dir;
	logic [TIME_W-1:0] tp_period;
	logic [TIME_W-1:0] tp_width;
	logic [TIME_W-1:0] tp_cnt;
	logic [TIME_W-1:0] stamp0;
	logic [TIME_W-1:0] stamp1;
	logic [ST_W-1:0]   status;
	logic [ST_W-1:0]   irq_en;
	logic              strap_done;
	logic              strap_high;
	logic              tm_q;
	logic              ant_q;
	pin_drive_t        next_pins;
	logic [2:0]        tp_drive;
	logic              tm_now;
	logic              tm_rise;
	logic              tm_fall;
	logic              pri_on67;
	logic              pri_on1516;
	logic              tp_level;
	logic              wr;
	logic              rd;
	logic              mapped;
	logic [31:0]       rd_word;
	logic [ST_W-1:0]   ev_set;
	logic [ST_W-1:0]   clr_bits;

	// the access phase answers one cycle late so every bus output is a flop
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && !pready && !pwrite;
	assign clr_bits = (wr && paddr == ADDR_CLR) ? pwdata[ST_W-1:0] : '0;

	// strap_done stays low until first edge after release so pins 10/12 stay inputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strap_done <= 1'b0;
			strap_high <= 1'b0;
		end else if (ce && !strap_done) begin
			strap_done <= 1'b1;
			strap_high <= pin_in[PIN_STRAP];
		end
	end

	assign pri_on67   = strap_high && !cfg.pri_alt;
	assign pri_on1516 = strap_high && cfg.pri_alt;

	// time pulse grid: restarted by the grid tick, so it stays phase locked
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tp_cnt <= '0;
		end else if (ce) begin
			if (grid_tick || tp_cnt >= tp_period - 32'h1) begin
				tp_cnt <= '0;
			end else begin
				tp_cnt <= tp_cnt + 32'h1;
			end
		end
	end
	assign tp_level = (tp_period != '0) && (tp_cnt < tp_width);

	always_comb begin
		next_pins.out = gpio_out;
		next_pins.drv = gpio_dir;
		tp_drive = 3'b000;
		tm_now = 1'b0;
		if (!strap_done) begin
			next_pins.drv[PIN_STRAP] = 1'b0;
			next_pins.drv[PIN_BOOT] = 1'b0;
		end
		if (pri_on67) begin
			next_pins.out[PIN_PRI_TX] = pri_txd;
			next_pins.drv[PIN_PRI_TX] = 1'b1;
			next_pins.drv[PIN_PRI_RX] = 1'b0;
		end else if (pri_on1516) begin
			// pins held idle: the serial peripheral function is never enabled
			next_pins.drv[PIN_PRI_TX] = 1'b0;
			next_pins.drv[PIN_PRI_RX] = 1'b0;
		end
		if (pri_on1516) begin
			next_pins.out[PIN_ANT_OUT] = pri_txd;
			next_pins.drv[PIN_ANT_OUT] = 1'b1;
		end else begin
			next_pins.out[PIN_ANT_OUT] = cfg.p16_speed ? speed_pulse
				: !pin_in[PIN_ANT_IN];
			next_pins.drv[PIN_ANT_OUT] = 1'b1;
		end
		next_pins.drv[PIN_ANT_IN] = 1'b0;
		case (cfg.sec_sel)
			SEC_A: begin
				next_pins.out[PIN_SEC_TX_A] = sec_txd;
				next_pins.drv[PIN_SEC_TX_A] = 1'b1;
				next_pins.drv[PIN_SEC_RX_A] = 1'b0;
			end
			SEC_B: begin
				next_pins.out[PIN_BOOT] = sec_txd;
				next_pins.drv[PIN_BOOT] = strap_done;
				next_pins.drv[PIN_STRAP] = 1'b0;
			end
			SEC_C: begin
				next_pins.out[PIN_SEC_TX_B] = sec_txd;
				next_pins.drv[PIN_SEC_TX_B] = 1'b1;
				next_pins.drv[PIN_SEC_RX_B] = 1'b0;
			end
			default: begin
			end
		endcase
		// a pin already carrying the secondary port keeps it over the pulse
		case (cfg.tp_sel)
			TP_P2: tp_drive[0] = (cfg.sec_sel != SEC_C);
			TP_P3: tp_drive[1] = (cfg.sec_sel != SEC_C);
			TP_P11: tp_drive[2] = 1'b1;
			default: tp_drive = 3'b000;
		endcase
		if (tp_drive[0]) begin
			next_pins.out[PIN_SEC_TX_B] = tp_level;
			next_pins.drv[PIN_SEC_TX_B] = 1'b1;
		end
		if (tp_drive[1]) begin
			next_pins.out[PIN_SEC_RX_B] = tp_level;
			next_pins.drv[PIN_SEC_RX_B] = 1'b1;
		end
		if (tp_drive[2]) begin
			next_pins.out[PIN_TP_HOME] = tp_level;
			next_pins.drv[PIN_TP_HOME] = 1'b1;
		end
		case (cfg.p13_fn)
			P13_NONE: next_pins.drv[PIN_P13] = 1'b0;
			P13_EVT: next_pins.drv[PIN_P13] = 1'b0;
			P13_CTS: next_pins.drv[PIN_P13] = 1'b0;
			P13_SCL: begin
				next_pins.out[PIN_P13] = 1'b0;
				next_pins.drv[PIN_P13] = i2c_scl_low;
			end
			default: next_pins.drv[PIN_P13] = 1'b0;
		endcase
		if (cfg.p14_fn != P14_RSV) begin
			next_pins.drv[PIN_P14] = 1'b0;
		end
		// only one pin feeds the time mark, and only if it is free for it
		case (cfg.tm_sel)
			TM_P11: tm_now = !tp_drive[2] && pin_in[PIN_TP_HOME];
			TM_P13: tm_now = (cfg.p13_fn == P13_EVT) && pin_in[PIN_P13];
			TM_P14: tm_now = (cfg.p14_fn == P14_EVT) && pin_in[PIN_P14];
			default: tm_now = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_out  <= '0;
			pin_oe_n <= '1;
		end else if (ce) begin
			pin_out  <= next_pins.out;
			pin_oe_n <= ~next_pins.drv;
		end
	end

	// core-side inputs; receive lines idle high when not routed
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pri_rxd <= 1'b1;
			pri_cts <= 1'b0;
			sec_rxd <= 1'b1;
			i2c_scl_in <= 1'b1;
			antenna_detect_in <= 1'b0;
			antenna_short_in <= 1'b0;
		end else if (ce) begin
			pri_rxd <= pri_on67 ? pin_in[PIN_PRI_RX]
				: pri_on1516 ? pin_in[PIN_ANT_IN] : 1'b1;
			pri_cts <= (cfg.p13_fn == P13_CTS) && pin_in[PIN_P13];
			case (cfg.sec_sel)
				SEC_A: sec_rxd <= pin_in[PIN_SEC_RX_A];
				SEC_B: sec_rxd <= pin_in[PIN_STRAP];
				SEC_C: sec_rxd <= pin_in[PIN_SEC_RX_B];
				default: sec_rxd <= 1'b1;
			endcase
			i2c_scl_in <= (cfg.p13_fn == P13_SCL) ? pin_in[PIN_P13] : 1'b1;
			antenna_detect_in <= (cfg.p14_fn == P14_DET) && pin_in[PIN_P14];
			antenna_short_in <= cfg.p15_short && !pri_on1516 && pin_in[PIN_ANT_IN];
		end
	end

	// time mark edges: rising on line 0, falling on line 1
	assign tm_rise = tm_now && !tm_q;
	assign tm_fall = !tm_now && tm_q;
	assign ev_set = {ant_q != pin_in[PIN_ANT_IN], tm_fall, tm_rise};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tm_q <= 1'b0;
			ant_q <= 1'b0;
			external_event_line0 <= 1'b0;
			external_event_line1 <= 1'b0;
			stamp0 <= '0;
			stamp1 <= '0;
		end else if (ce) begin
			tm_q <= tm_now;
			ant_q <= pin_in[PIN_ANT_IN];
			external_event_line0 <= tm_rise;
			external_event_line1 <= tm_fall;
			if (tm_rise) begin
				stamp0 <= gps_time;
			end
			if (tm_fall) begin
				stamp1 <= gps_time;
			end
		end
	end

	// sticky status: a new event in the clearing cycle survives
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			status <= (status & ~clr_bits) | ev_set;
			irq <= |(status & irq_en);
		end
	end

	// software-written configuration
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg <= CFG_DEF;
			gpio_out <= '0;
			gpio_dir <= '0;
			pull_up_en <= PULL_DEF;
			pri_baud_div <= BAUD_DEF_DIV;
			sec_baud_div <= BAUD_DEF_DIV;
			tp_period <= TP_PER_DEF;
			tp_width <= TP_WID_DEF;
			irq_en <= '0;
		end else if (ce && wr) begin
			case (paddr)
				ADDR_CTRL: cfg <= mux_cfg_t'(pwdata[CFG_W-1:0]);
				ADDR_GOUT: gpio_out <= pwdata[NPIN-1:0];
				ADDR_GDIR: gpio_dir <= pwdata[NPIN-1:0];
				ADDR_PULL: pull_up_en <= pwdata[NPIN-1:0];
				// divisors below the fastest supported rate are clamped
				ADDR_BAUD1: pri_baud_div <= (pwdata[BAUD_W-1:0] < BAUD_MIN_DIV)
					? BAUD_MIN_DIV : pwdata[BAUD_W-1:0];
				ADDR_BAUD2: sec_baud_div <= (pwdata[BAUD_W-1:0] < BAUD_MIN_DIV)
					? BAUD_MIN_DIV : pwdata[BAUD_W-1:0];
				ADDR_TPPER: tp_period <= pwdata;
				ADDR_TPWID: tp_width <= pwdata;
				ADDR_IEN: irq_en <= pwdata[ST_W-1:0];
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		mapped = 1'b1;
		rd_word = '0;
		case (paddr)
			ADDR_CTRL: rd_word[CFG_W-1:0] = cfg;
			ADDR_GOUT: rd_word[NPIN-1:0] = gpio_out;
			ADDR_GDIR: rd_word[NPIN-1:0] = gpio_dir;
			ADDR_GIN: rd_word[NPIN-1:0] = pin_in;
			ADDR_PULL: rd_word[NPIN-1:0] = pull_up_en;
			ADDR_BAUD1: rd_word[BAUD_W-1:0] = pri_baud_div;
			ADDR_BAUD2: rd_word[BAUD_W-1:0] = sec_baud_div;
			ADDR_TPPER: rd_word = tp_period;
			ADDR_TPWID: rd_word = tp_width;
			ADDR_STAT: rd_word[ST_W-1:0] = status;
			ADDR_CLR: rd_word = '0;
			ADDR_IEN: rd_word[ST_W-1:0] = irq_en;
			ADDR_STAMP0: rd_word = stamp0;
			ADDR_STAMP1: rd_word = stamp1;
			ADDR_STATE: rd_word[1:0] = {strap_done, strap_high};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= psel && penable && !pready;
			prdata <= rd ? rd_word : '0;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	a_pull_reset: assert property (@(posedge clk_sys) $past(rst)
		|-> pull_up_en[PIN_STRAP] && pull_up_en[PIN_BOOT])
		else $error("strap pull-ups not on after reset");
	a_pri_home: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && pri_on67) ##1 ce |-> !pin_oe_n[PIN_PRI_TX]
		&& pin_out[PIN_PRI_TX] == $past(pri_txd))
		else $error("primary transmit not on pin 6");
	a_pri_moved: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && pri_on1516) ##1 ce |-> pin_oe_n[PIN_PRI_TX] && pin_oe_n[PIN_PRI_RX]
		&& pin_out[PIN_ANT_OUT] == $past(pri_txd))
		else $error("primary port not moved to pins 15/16");
	a_sec_route: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && cfg.sec_sel == SEC_C) ##1 ce |-> !pin_oe_n[PIN_SEC_TX_B]
		&& pin_out[PIN_SEC_TX_B] == $past(sec_txd))
		else $error("secondary transmit not on pin 2");
	a_gpio_low: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && strap_done && !strap_high && gpio_dir[PIN_PRI_TX]) ##1 ce
		|-> pin_out[PIN_PRI_TX] == $past(gpio_out[PIN_PRI_TX]))
		else $error("pin 6 not GPIO with strap low");
	// watched at the pins: with the pulse on pin 2, pins 3 and 11 must be released
	a_tp_single: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && cfg.tp_sel == TP_P2 && cfg.sec_sel != SEC_C && !gpio_dir[PIN_SEC_RX_B]
		&& !gpio_dir[PIN_TP_HOME]) ##1 ce
		|-> pin_oe_n[PIN_SEC_RX_B] && pin_oe_n[PIN_TP_HOME])
		else $error("more than one time pulse pin");
	a_ant_follow: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && !pri_on1516 && !cfg.p16_speed) ##1 ce
		|-> pin_out[PIN_ANT_OUT] == !$past(pin_in[PIN_ANT_IN]))
		else $error("antenna control does not follow status");
	a_event_stamp: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && tm_rise) ##1 ce |-> external_event_line0 && status[ST_EV0]
		&& stamp0 == $past(gps_time))
		else $error("time mark event not stamped");
	a_baud_floor: assert property (@(posedge clk_sys) disable iff (rst)
		pri_baud_div >= BAUD_MIN_DIV && sec_baud_div >= BAUD_MIN_DIV)
		else $error("baud divisor above top rate");
	a_strap_hold: assert property (@(posedge clk_sys) disable iff (rst)
		strap_done |=> strap_done && $stable(strap_high))
		else $error("strap mapping changed after sampling");
	a_p13_idle: assert property (@(posedge clk_sys) $past(rst) && !rst
		|-> pin_oe_n[PIN_P13] && pin_oe_n[PIN_P14])
		else $error("pin 13 or 14 driven after reset");
endmodule
`default_nettype wire

// [pio_mux_pkg.sv]
// package: constants, register map and carriers for the pin function mux
// Functional notes
// - primary serial port on pins 6/7 by default
// - serial peripheral reservation moves primary to 15/16
// - secondary port on 17/18, 10/12 or 2/3
// - configurable baud, at most 921600 bps
// - pins 6/7 serial only if strap high
// - pull-ups on pins 10 and 12 default on
// - time mark from pin 11, 13 or 14
// - two event lines, each timestamped
// - time pulse on one of pins 2/3/11
// - time pulse train aligned to time grid
// - each pin is GPIO or a listed function
// - antenna power follows antenna status pin
// - pin 13: none, event, CTS or SCL
// - pin 14: none, event or antenna detect
// - serial peripheral function never made active
package pio_mux_pkg;
	localparam int NPIN   = 19;
	localparam int ADDR_W = 8;
	localparam int TIME_W = 32;
	localparam int BAUD_W = 16;

	localparam int PIN_SEC_TX_B = 2;
	localparam int PIN_SEC_RX_B = 3;
	localparam int PIN_PRI_TX   = 6;
	localparam int PIN_PRI_RX   = 7;
	localparam int PIN_STRAP    = 10;
	localparam int PIN_TP_HOME  = 11;
	localparam int PIN_BOOT     = 12;
	localparam int PIN_P13      = 13;
	localparam int PIN_P14      = 14;
	localparam int PIN_ANT_IN   = 15;
	localparam int PIN_ANT_OUT  = 16;
	localparam int PIN_SEC_RX_A = 17;
	localparam int PIN_SEC_TX_A = 18;

	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_GOUT   = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_GDIR   = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_GIN    = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_PULL   = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_BAUD1  = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_BAUD2  = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_TPPER  = 8'h1c;
	localparam logic [ADDR_W-1:0] ADDR_TPWID  = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_STAT   = 8'h24;
	localparam logic [ADDR_W-1:0] ADDR_CLR    = 8'h28;
	localparam logic [ADDR_W-1:0] ADDR_IEN    = 8'h2c;
	localparam logic [ADDR_W-1:0] ADDR_STAMP0 = 8'h30;
	localparam logic [ADDR_W-1:0] ADDR_STAMP1 = 8'h34;
	localparam logic [ADDR_W-1:0] ADDR_STATE  = 8'h38;

	localparam int CLK_HZ      = 50_000_000;
	localparam int BAUD_MAX    = 921_600;
	localparam int BAUD_DEF    = 9_600;
	localparam logic [BAUD_W-1:0] BAUD_MIN_DIV = BAUD_W'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
	localparam logic [BAUD_W-1:0] BAUD_DEF_DIV = BAUD_W'(CLK_HZ / BAUD_DEF);
	localparam logic [TIME_W-1:0] TP_PER_DEF   = 32'h02fa_f080;
	localparam logic [TIME_W-1:0] TP_WID_DEF   = 32'h004c_4b40;

	localparam logic [NPIN-1:0] PULL_DEF = 19'h0_1400;

	// status bits
	localparam int ST_EV0 = 0;
	localparam int ST_EV1 = 1;
	localparam int ST_ANT = 2;
	localparam int ST_W   = 3;

	typedef enum logic [1:0] {
		SEC_A  = 2'b00,
		SEC_B  = 2'b01,
		SEC_C  = 2'b10,
		SEC_NO = 2'b11
	} sec_sel_t;

	typedef enum logic [1:0] {
		TP_OFF = 2'b00,
		TP_P2  = 2'b01,
		TP_P3  = 2'b10,
		TP_P11 = 2'b11
	} tp_sel_t;

	typedef enum logic [1:0] {
		TM_OFF = 2'b00,
		TM_P11 = 2'b01,
		TM_P13 = 2'b10,
		TM_P14 = 2'b11
	} tm_sel_t;

	typedef enum logic [1:0] {
		P13_NONE = 2'b00,
		P13_EVT  = 2'b01,
		P13_CTS  = 2'b10,
		P13_SCL  = 2'b11
	} p13_fn_t;

	typedef enum logic [1:0] {
		P14_NONE = 2'b00,
		P14_EVT  = 2'b01,
		P14_DET  = 2'b10,
		P14_RSV  = 2'b11
	} p14_fn_t;

	typedef struct packed {
		logic     p16_speed;
		logic     p15_short;
		p14_fn_t  p14_fn;
		p13_fn_t  p13_fn;
		tm_sel_t  tm_sel;
		tp_sel_t  tp_sel;
		sec_sel_t sec_sel;
		logic     pri_alt;
	} mux_cfg_t;

	localparam int CFG_W = $bits(mux_cfg_t);
	localparam mux_cfg_t CFG_DEF = '{
		p16_speed: 1'b0, p15_short: 1'b0, p14_fn: P14_NONE, p13_fn: P13_NONE,
		tm_sel: TM_OFF, tp_sel: TP_P11, sec_sel: SEC_A, pri_alt: 1'b0};

	typedef struct packed {
		logic [NPIN-1:0] out;
		logic [NPIN-1:0] drv;
	} pin_drive_t;
endpackage

// [host_pin_model.sv]
// host side of the multiplexed pins: resolves each pin from both drivers and the pulls
`timescale 1ns/1ps
`default_nettype none
module host_pin_model
	import pio_mux_pkg::*;
(
	// clock
	input  wire logic            clk_sys,
	// device side
	input  wire logic [NPIN-1:0] pin_out,
	input  wire logic [NPIN-1:0] pin_oe_n,
	input  wire logic [NPIN-1:0] pull_up_en,
	// host side
	input  wire logic [NPIN-1:0] host_drv,
	input  wire logic [NPIN-1:0] host_val,
	// resolved levels
	output logic      [NPIN-1:0] pin_in
);
	logic flip = 1'b0;

	// a floating pin wanders so that a stale level never passes for a driven one
	always_ff @(posedge clk_sys) flip <= ~flip;

	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			// the device wins a clash: an open-drain low pulls the wire down
			if (!pin_oe_n[i])
				pin_in[i] = pin_out[i];
			else if (host_drv[i])
				pin_in[i] = host_val[i];
			else
				pin_in[i] = pull_up_en[i] ? 1'b1 : flip ^ i[0];
		end
	end
endmodule
`default_nettype wire

// [pio_function_mux_tb_top.sv]
// testbench for the pin function mux: apb tasks and directed pin scenarios
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
	$display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module pio_function_mux_tb_top import pio_mux_pkg::*; ;
	logic clk_sys, pready, pslverr, irq, pri_rxd, pri_cts, sec_rxd, i2c_scl_in, err;
	logic external_event_line0, external_event_line1, antenna_detect_in, antenna_short_in;
	logic rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pri_txd = 1'b1, sec_txd = 1'b1, i2c_scl_low = 1'b0;
	logic grid_tick = 1'b0, speed_pulse = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0, prdata, rv;
	logic [NPIN-1:0]   pin_in, pin_out, pin_oe_n, pull_up_en;
	logic [NPIN-1:0]   host_drv = '0, host_val = '0;
	logic [BAUD_W-1:0] pri_baud_div, sec_baud_div;
	logic [TIME_W-1:0] gps_time = '0;
	int                failures = 0, checks_done = 0, n0 = 0, n1 = 0, hi, multi;
	int                rxp[3] = '{17, 10, 3}, txp[3] = '{18, 12, 2};
	int                tpp[3] = '{2, 3, 11}, tmk[3] = '{11, 13, 14};
	mux_cfg_t          c;

	pio_function_mux uut (.clk_sys, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .irq, .pin_in, .pin_out, .pin_oe_n, .pull_up_en,
		.pri_txd, .sec_txd, .pri_rxd, .pri_cts, .sec_rxd, .pri_baud_div, .sec_baud_div,
		.i2c_scl_low, .i2c_scl_in, .gps_time, .grid_tick, .speed_pulse,
		.external_event_line0, .external_event_line1, .antenna_detect_in,
		.antenna_short_in);

	host_pin_model host (.clk_sys, .pin_out, .pin_oe_n, .pull_up_en, .host_drv,
		.host_val, .pin_in);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (external_event_line0 === 1'b1)
			n0++;
		if (external_event_line1 === 1'b1)
			n1++;
	end

	task automatic complete_run();
		$display("failures %0d checks_done %0d", failures, checks_done);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#400_000;
		failures++;
		complete_run();
	end

	task automatic rw(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		rw(a, 1'b1, d);
	endtask

	task automatic cw();
		wr(ADDR_CTRL, 32'(c));
	endtask

	task automatic hp(input int p, input logic v);
		@(posedge clk_sys);
		host_drv[p] <= 1'b1;
		host_val[p] <= v;
	endtask

	// pins are sampled, then registered: four edges cover both stages
	task automatic st();
		repeat (4) @(posedge clk_sys);
		#1;
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		st();
		`CHK(pull_up_en, 19'h0_1400)
		`CHK(pin_oe_n[14:13], 2'h3)
		`CHK(pri_baud_div, 16'h1458)
		rw(ADDR_CTRL, 1'b0, '0);
		`CHK(rv, 32'h18)
		rw(ADDR_STATE, 1'b0, '0);
		`CHK(rv, 32'h3)
		rw(8'h3c, 1'b0, '0);
		`CHK(err, 1'b1)
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys) pri_txd <= v[0];
			hp(PIN_PRI_RX, !v[0]);
			st();
			`CHK({pin_oe_n[6], pin_out[6]}, {1'b0, v[0]})
			`CHK(pri_rxd, !v[0])
		end
		// enable low must freeze the pins even while the core keeps transmitting
		@(posedge clk_sys) ce <= 1'b0;
		pri_txd <= 1'b0;
		st();
		`CHK(pin_out[PIN_PRI_TX], 1'b1)
		@(posedge clk_sys) ce <= 1'b1;
		for (int v = 0; v < 2; v++) begin
			hp(PIN_ANT_IN, v[0]);
			st();
			`CHK(pin_out[PIN_ANT_OUT], !v[0])
			if (v == 0) begin
				wr(ADDR_CLR, 32'h7);
				rw(ADDR_STAT, 1'b0, '0);
				`CHK(rv[ST_ANT], 1'b0)
			end
		end
		rw(ADDR_STAT, 1'b0, '0);
		`CHK(rv[ST_ANT], 1'b1)
		c = CFG_DEF;
		c.p16_speed = 1'b1;
		c.p15_short = 1'b1;
		cw();
		@(posedge clk_sys) speed_pulse <= 1'b1;
		st();
		`CHK({pin_out[PIN_ANT_OUT], antenna_short_in}, 2'h3)
		c = CFG_DEF;
		c.pri_alt = 1'b1;
		cw();
		@(posedge clk_sys) pri_txd <= 1'b0;
		hp(PIN_ANT_IN, 1'b0);
		st();
		`CHK(pin_oe_n[7:6], 2'h3)
		`CHK({pin_out[PIN_ANT_OUT], pri_rxd}, 2'h0)
		c = CFG_DEF;
		for (int i = 0; i < 3; i++) begin
			c.sec_sel = sec_sel_t'(i);
			cw();
			for (int v = 0; v < 2; v++) begin
				@(posedge clk_sys) sec_txd <= v[0];
				hp(rxp[i], !v[0]);
				st();
				`CHK({pin_oe_n[txp[i]], pin_out[txp[i]]}, {1'b0, v[0]})
				`CHK(sec_rxd, !v[0])
			end
		end
		wr(ADDR_BAUD1, 32'h1);
		wr(ADDR_BAUD2, 32'h3e8);
		st();
		`CHK(pri_baud_div, 16'((50_000_000 + 921_599) / 921_600))
		`CHK(sec_baud_div, 16'h3e8)
		wr(ADDR_TPPER, 32'ha);
		wr(ADDR_TPWID, 32'h3);
		c.sec_sel = SEC_NO;
		for (int i = 1; i < 4; i++) begin
			c.tp_sel = tp_sel_t'(i);
			cw();
			@(posedge clk_sys) grid_tick <= 1'b1;
			@(posedge clk_sys) grid_tick <= 1'b0;
			hi = 0;
			multi = 0;
			repeat (20) begin
				@(posedge clk_sys) #1;
				hi += (pin_out[tpp[i-1]] === 1'b1 && pin_oe_n[tpp[i-1]] === 1'b0);
				multi += (!pin_oe_n[2] + !pin_oe_n[3] + !pin_oe_n[11] > 1);
			end
			`CHK(hi inside {[4:8]}, 1'b1)
			`CHK(multi, 0)
		end
		wr(ADDR_IEN, 32'h3);
		c.tp_sel = TP_OFF;
		for (int i = 0; i < 3; i++) begin
			c.tm_sel = tm_sel_t'(i + 1);
			c.p13_fn = (i == 1) ? P13_EVT : P13_NONE;
			c.p14_fn = (i == 2) ? P14_EVT : P14_NONE;
			cw();
			hp(tmk[i], 1'b0);
			hp(tmk[(i + 1) % 3], 1'b0);
			st();
			wr(ADDR_CLR, 32'h7);
			st();
			`CHK(irq, 1'b0)
			n0 = 0;
			n1 = 0;
			for (int v = 1; v >= 0; v--) begin
				@(posedge clk_sys) gps_time <= 32'h100 * i + v + 5;
				hp(tmk[i], v[0]);
				st();
				rw(v ? ADDR_STAMP0 : ADDR_STAMP1, 1'b0, '0);
				`CHK(rv, 32'h100 * i + v + 5)
			end
			`CHK(n0, 1)
			`CHK(n1, 1)
			`CHK(irq, 1'b1)
			hp(tmk[(i + 1) % 3], 1'b1);
			st();
			`CHK(n0, 1)
		end
		wr(ADDR_IEN, 32'h0);
		st();
		`CHK(irq, 1'b0)
		rw(ADDR_STAT, 1'b0, '0);
		`CHK(rv[1:0], 2'h3)
		c = CFG_DEF;
		c.p13_fn = P13_CTS;
		c.p14_fn = P14_DET;
		cw();
		for (int v = 0; v < 2; v++) begin
			hp(PIN_P13, v[0]);
			hp(PIN_P14, !v[0]);
			st();
			`CHK(pri_cts, v[0])
			`CHK(antenna_detect_in, !v[0])
		end
		c.p13_fn = P13_SCL;
		cw();
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys) i2c_scl_low <= !v[0];
			st();
			`CHK({pin_oe_n[13], i2c_scl_in}, {v[0], v[0]})
		end
		c.p14_fn = P14_RSV;
		cw();
		wr(ADDR_GDIR, 32'h4010);
		wr(ADDR_GOUT, 32'h4010);
		hp(5, 1'b1);
		st();
		`CHK({pin_oe_n[4], pin_out[4]}, 2'h1)
		`CHK({pin_oe_n[14], pin_out[14]}, 2'h1)
		rw(ADDR_GIN, 1'b0, '0);
		`CHK(rv[5], 1'b1)
		hp(PIN_STRAP, 1'b0);
		st();
		rw(ADDR_STATE, 1'b0, '0);
		`CHK(rv, 32'h3)
		@(posedge clk_sys) rst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		st();
		rw(ADDR_STATE, 1'b0, '0);
		`CHK(rv, 32'h2)
		`CHK(pin_oe_n[6], 1'b1)
		wr(ADDR_GDIR, 32'h40);
		wr(ADDR_GOUT, 32'h40);
		st();
		`CHK({pin_oe_n[6], pin_out[6]}, 2'h1)
		complete_run();
	end
endmodule
`default_nettype wire
